// *** verilog/frt_pkg.sv ***
// package: types, field layout and constants of the fp round-to-integer unit
package frt_pkg;
   // architecture revision that first carries round-to-integral-value
   localparam int FRT_MIN_REV = 6;
   // floating-point layouts
   localparam int FRT_D_FRAC = 52;
   localparam int FRT_S_FRAC = 23;
   localparam logic [12:0] FRT_D_BIAS = 13'h03ff;
   localparam logic [12:0] FRT_S_BIAS = 13'h007f;
   localparam int FRT_SIG_W = 53;
   localparam int FRT_MAG_W = 65;
   localparam int FRT_MAX_EXP = 63;
   // fixed-point limits of the two targets
   localparam logic [63:0] FRT_L_POS_MAX = 64'h7fff_ffff_ffff_ffff;
   localparam logic [63:0] FRT_L_NEG_MIN = 64'h8000_0000_0000_0000;
   localparam logic [63:0] FRT_W_POS_MAX = 64'h0000_0000_7fff_ffff;
   localparam logic [63:0] FRT_W_NEG_MIN = 64'h0000_0000_8000_0000;
   // register map
   localparam logic [3:0] FRT_ADDR_CSR = 4'h0;
   localparam logic [3:0] FRT_ADDR_CAUSE = 4'h4;
   localparam int FRT_CSR_RM_LO = 0;
   localparam int FRT_CSR_RM_HI = 1;
   localparam int FRT_CSR_FLAG_INEXACT = 2;
   localparam int FRT_CSR_FLAG_INVALID = 3;
   localparam int FRT_CSR_EN_INVALID = 4;
   localparam int FRT_CSR_NAN_DFLT = 5;
   localparam logic FRT_NAN_DFLT_RST = 1'b1;

   typedef enum logic [1:0] {FRT_OP_INTG, FRT_OP_RND_L, FRT_OP_RND_W, FRT_OP_RSVD} frt_op_t;
   typedef enum logic [1:0] {FRT_TAG_S, FRT_TAG_D, FRT_TAG_W, FRT_TAG_L} frt_tag_t;
   typedef enum logic [1:0] {FRT_RM_NEAR, FRT_RM_ZERO, FRT_RM_PINF, FRT_RM_NINF} frt_rm_t;

   typedef struct packed {
      frt_op_t op;
      frt_tag_t fmt;
      logic [4:0] dst;
      logic [63:0] src;
   } frt_req_t;

   typedef struct packed {
      logic we;
      frt_tag_t fmt;
      logic [4:0] dst;
      logic [63:0] data;
   } frt_res_t;

   typedef struct packed {
      logic cop_unusable;
      logic reserved_instr;
      logic invalid_trap;
   } frt_exc_t;
endpackage : frt_pkg

// *** verilog/frt_round_core.sv ***
// integer part, rounding decision and inexact detection for an unpacked value
`timescale 1ns/1ps
`default_nettype none
module frt_round_core (
   // unpacked operand
   input wire logic sign,
   input wire logic signed [12:0] exp_unb,
   input wire logic [frt_pkg::FRT_SIG_W-1:0] sig,
   // rounding direction
   input wire frt_pkg::frt_rm_t rm,
   // results
   output logic [frt_pkg::FRT_MAG_W-1:0] mag,
   output logic round_up,
   output logic inexact,
   output logic huge
);
   localparam int W2 = 2 * frt_pkg::FRT_SIG_W;
   localparam logic signed [12:0] FRAC_TOP = 13'sd52;
   localparam logic signed [12:0] EXP_TOP = 13'sd63;
   localparam logic signed [12:0] SH_MAX = 13'sd105;

   logic [W2-1:0] wide;
   logic [frt_pkg::FRT_SIG_W-1:0] int_part;
   logic guard;
   logic sticky;
   logic signed [12:0] sh;

   // split the significand at the binary point; shifts are bounded so no bit is lost silently
   always_comb begin
      wide = '0;
      int_part = '0;
      guard = 1'b0;
      sticky = 1'b0;
      huge = 1'b0;
      sh = FRAC_TOP - exp_unb;
      mag = '0;
      if (exp_unb > EXP_TOP) begin
         huge = 1'b1;
      end else if (exp_unb > FRAC_TOP) begin
         mag = {12'h000, sig} << 7'(exp_unb - FRAC_TOP);
      end else if (sh > SH_MAX) begin
         sticky = |sig;
      end else begin
         wide = {sig, 53'h0} >> 7'(sh);
         int_part = wide[W2-1:frt_pkg::FRT_SIG_W];
         guard = wide[frt_pkg::FRT_SIG_W-1];
         sticky = |wide[frt_pkg::FRT_SIG_W-2:0];
      end
      // direction of rounding from the selected mode
      case (rm)
         frt_pkg::FRT_RM_NEAR: round_up = guard & (sticky | int_part[0]);
         frt_pkg::FRT_RM_ZERO: round_up = 1'b0;
         frt_pkg::FRT_RM_PINF: round_up = ~sign & (guard | sticky);
         frt_pkg::FRT_RM_NINF: round_up = sign & (guard | sticky);
         default: round_up = 1'b0;
      endcase
      inexact = guard | sticky;
      if (!huge && exp_unb <= FRAC_TOP) begin
         mag = {12'h000, int_part} + {64'h0, round_up};
      end
   end
endmodule : frt_round_core
`default_nettype wire

// *** verilog/frt_unit.sv ***
// fp round-to-integral, round-to-long and round-to-word execution unit
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module frt_unit #(
   parameter int ARCH_REV = 6,
   parameter bit SINGLE_IMPL = 1'b1,
   parameter bit DOUBLE_IMPL = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // instruction issue from the pipeline
   input wire logic req_valid,
   input wire frt_pkg::frt_req_t req,
   input wire logic cop1_enable,
   // result toward the fp register file
   output logic res_valid,
   output frt_pkg::frt_res_t res,
   output frt_pkg::frt_exc_t exc,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // control register state
   frt_pkg::frt_rm_t rm_reg, rm_next;
   logic flag_inexact_reg, flag_inexact_next;
   logic flag_invalid_reg, flag_invalid_next;
   logic en_invalid_reg, en_invalid_next;
   logic nan_dflt_reg, nan_dflt_next;
   logic [1:0] cause_reg, cause_next;
   logic [31:0] rdata_reg, rdata_next;
   // result state
   logic res_valid_reg, res_valid_next;
   frt_pkg::frt_res_t res_reg, res_next;
   frt_pkg::frt_exc_t exc_reg, exc_next;

   // unpacked operand
   logic is_d;
   logic sign;
   logic [10:0] expf;
   logic [51:0] frac;
   logic exp_ones;
   logic is_nan;
   logic is_inf;
   logic is_snan;
   logic [12:0] bias;
   logic signed [12:0] exp_unb;
   logic [frt_pkg::FRT_SIG_W-1:0] sig;
   frt_pkg::frt_rm_t rm_use;
   logic [frt_pkg::FRT_MAG_W-1:0] mag;
   logic round_up;
   logic core_inexact;
   logic huge;

   // fraction width of a source format, used by mask and quiet-bit logic
   function automatic logic [5:0] frac_bits(input logic dbl);
      frac_bits = dbl ? 6'(frt_pkg::FRT_D_FRAC) : 6'(frt_pkg::FRT_S_FRAC);
   endfunction : frac_bits

   // split single or double into sign, unbiased exponent and significand
   always_comb begin
      // single operands sit in the low word; the upper word is ignored
      is_d = (req.fmt == frt_pkg::FRT_TAG_D);
      sign = is_d ? req.src[63] : req.src[31];
      expf = is_d ? req.src[62:52] : {3'h0, req.src[30:23]};
      frac = is_d ? req.src[51:0] : {req.src[22:0], 29'h0};
      exp_ones = is_d ? (&req.src[62:52]) : (&req.src[30:23]);
      // all-ones exponent: infinity with a zero fraction, NaN otherwise
      is_nan = exp_ones & (|frac);
      is_inf = exp_ones & ~(|frac);
      // legacy mode marks signalling NaNs with the top fraction bit set
      is_snan = is_nan & (nan_dflt_reg ? ~frac[51] : frac[51]);
      bias = is_d ? frt_pkg::FRT_D_BIAS : frt_pkg::FRT_S_BIAS;
      // subnormals use the minimum exponent with no hidden bit
      exp_unb = (expf == 11'h000) ? signed'(13'h0001 - bias) : signed'({2'h0, expf} - bias);
      // hidden bit restored for every nonzero exponent field, infinities and NaNs included
      sig = {(expf != 11'h000), frac};
      // conversions ignore the control field and always round to nearest-even
      rm_use = (req.op == frt_pkg::FRT_OP_INTG) ? rm_reg : frt_pkg::FRT_RM_NEAR;
   end

   // one shared rounding core serves all three operations
   frt_round_core u_core (
      .sign(sign),
      .exp_unb(exp_unb),
      .sig(sig),
      .rm(rm_use),
      .mag(mag),
      .round_up(round_up),
      .inexact(core_inexact),
      .huge(huge)
   );

   // datapath results for each operation
   logic [63:0] src_n;
   logic [5:0] fb;
   logic [63:0] mask;
   logic [63:0] one_val;
   logic [63:0] sign_bit;
   logic [63:0] quiet_nan;
   logic [63:0] rint_val;
   logic [frt_pkg::FRT_MAG_W-1:0] lim;
   logic is_long;
   logic oor;
   logic cvt_invalid;
   logic [63:0] cvt_val;
   logic [63:0] pos_max;
   logic [63:0] neg_min;
   logic [63:0] cvt_default;
   logic [63:0] neg_mag;

   always_comb begin
      src_n = is_d ? req.src : {32'h0, req.src[31:0]};
      fb = frac_bits(is_d);
      // sign and one sit at the positions of the source format
      sign_bit = is_d ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000;
      one_val = {51'h0, bias} << fb;
      mask = '0;
      // quieting keeps the payload nonzero in either NaN convention
      quiet_nan = src_n;
      if (nan_dflt_reg) begin
         quiet_nan[fb - 6'h01] = 1'b1;
      end else begin
         quiet_nan[fb - 6'h01] = 1'b0;
         quiet_nan[fb - 6'h02] = 1'b1;
      end
      // round to integral by clearing fraction bits; a carry walks into the exponent
      if (exp_ones) begin
         rint_val = is_nan ? quiet_nan : src_n;
      end else if (exp_unb >= signed'({7'h00, fb})) begin
         rint_val = src_n;
      end else if (exp_unb < 13'sd0) begin
         rint_val = (src_n & sign_bit) | (round_up ? one_val : 64'h0);
      end else begin
         mask = (64'h1 << 6'(13'(fb) - exp_unb)) - 64'h1;
         rint_val = (src_n & ~mask) + (round_up ? mask + 64'h1 : 64'h0);
      end
      // range check of the rounded integer against the signed target
      is_long = (req.op == frt_pkg::FRT_OP_RND_L);
      pos_max = is_long ? frt_pkg::FRT_L_POS_MAX : frt_pkg::FRT_W_POS_MAX;
      neg_min = is_long ? frt_pkg::FRT_L_NEG_MIN : frt_pkg::FRT_W_NEG_MIN;
      // a negative result may reach one step further than a positive one
      lim = {1'b0, sign ? neg_min : pos_max};
      oor = huge | (mag > lim);
      cvt_invalid = is_nan | is_inf | oor;
      // two's complement of the magnitude; a word result keeps the low half only
      neg_mag = 64'h0 - mag[63:0];
      cvt_val = sign ? neg_mag : mag[63:0];
      if (!is_long) begin
         cvt_val = {32'h0, cvt_val[31:0]};
      end
      // default results when the invalid trap is off
      if (!nan_dflt_reg) begin
         cvt_default = pos_max;
      end else if (is_nan) begin
         cvt_default = 64'h0;
      end else if (sign) begin
         cvt_default = neg_min;
      end else begin
         cvt_default = pos_max;
      end
   end

   // decode, exceptions, flags and result registers
   logic cop_unusable;
   logic rsvd;
   logic is_intg;
   logic invalid;
   logic trap;
   logic inexact;
   logic issue_ok;

   always_comb begin
      is_intg = (req.op == frt_pkg::FRT_OP_INTG);
      // priority: unusable first, then reserved, then invalid
      cop_unusable = req_valid & ~cop1_enable;
      rsvd = req_valid & cop1_enable & ((req.op == frt_pkg::FRT_OP_RSVD)
         | (req.fmt == frt_pkg::FRT_TAG_W) | (req.fmt == frt_pkg::FRT_TAG_L)
         | ((req.fmt == frt_pkg::FRT_TAG_S) & ~SINGLE_IMPL)
         | ((req.fmt == frt_pkg::FRT_TAG_D) & ~DOUBLE_IMPL)
         | (is_intg & (ARCH_REV < frt_pkg::FRT_MIN_REV)));
      issue_ok = req_valid & cop1_enable & ~rsvd;
      // only signalling NaNs make round-to-integral invalid; it never overflows
      invalid = issue_ok & (is_intg ? is_snan : cvt_invalid);
      // an enabled trap suppresses the write and reports at once
      trap = invalid & en_invalid_reg;
      inexact = issue_ok & ~invalid & core_inexact & ~exp_ones;

      // every issue slot answers one cycle later, even when refused
      res_valid_next = req_valid;
      exc_next.cop_unusable = cop_unusable;
      exc_next.reserved_instr = rsvd;
      exc_next.invalid_trap = trap;
      // data and format of a refused instruction keep their last values; dst and we still update
      res_next = res_reg;
      res_next.we = issue_ok & ~trap;
      res_next.dst = req.dst;
      // conversions retag the destination as fixed point
      if (issue_ok) begin
         if (is_intg) begin
            res_next.fmt = req.fmt;
            res_next.data = rint_val;
         end else begin
            res_next.fmt = is_long ? frt_pkg::FRT_TAG_L : frt_pkg::FRT_TAG_W;
            res_next.data = invalid ? cvt_default : cvt_val;
         end
      end

      // software writes the control word; a hardware set in the same cycle wins
      rm_next = rm_reg;
      en_invalid_next = en_invalid_reg;
      nan_dflt_next = nan_dflt_reg;
      flag_inexact_next = flag_inexact_reg;
      flag_invalid_next = flag_invalid_reg;
      if (reg_wr && reg_addr == frt_pkg::FRT_ADDR_CSR) begin
         rm_next = frt_pkg::frt_rm_t'(reg_wdata[frt_pkg::FRT_CSR_RM_HI:frt_pkg::FRT_CSR_RM_LO]);
         en_invalid_next = reg_wdata[frt_pkg::FRT_CSR_EN_INVALID];
         nan_dflt_next = reg_wdata[frt_pkg::FRT_CSR_NAN_DFLT];
         flag_inexact_next = reg_wdata[frt_pkg::FRT_CSR_FLAG_INEXACT];
         flag_invalid_next = reg_wdata[frt_pkg::FRT_CSR_FLAG_INVALID];
      end
      // hardware sets are ored in last so they beat a clearing write
      flag_invalid_next = flag_invalid_next | invalid;
      flag_inexact_next = flag_inexact_next | inexact;
      // cause holds the conditions of the last instruction that issued
      cause_next = issue_ok ? {invalid, inexact} : cause_reg;

      // read data stands only in the cycle after the strobe
      rdata_next = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            frt_pkg::FRT_ADDR_CSR: begin
               rdata_next[frt_pkg::FRT_CSR_RM_HI:frt_pkg::FRT_CSR_RM_LO] = rm_reg;
               rdata_next[frt_pkg::FRT_CSR_FLAG_INEXACT] = flag_inexact_reg;
               rdata_next[frt_pkg::FRT_CSR_FLAG_INVALID] = flag_invalid_reg;
               rdata_next[frt_pkg::FRT_CSR_EN_INVALID] = en_invalid_reg;
               rdata_next[frt_pkg::FRT_CSR_NAN_DFLT] = nan_dflt_reg;
            end
            frt_pkg::FRT_ADDR_CAUSE: rdata_next = {30'h0, cause_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   // registers; synchronous active-low reset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rm_reg <= frt_pkg::FRT_RM_NEAR;
         flag_inexact_reg <= 1'b0;
         flag_invalid_reg <= 1'b0;
         en_invalid_reg <= 1'b0;
         nan_dflt_reg <= frt_pkg::FRT_NAN_DFLT_RST;
         cause_reg <= 2'h0;
         rdata_reg <= 32'h0;
         res_valid_reg <= 1'b0;
         res_reg <= '0;
         exc_reg <= '0;
      end else begin
         rm_reg <= rm_next;
         flag_inexact_reg <= flag_inexact_next;
         flag_invalid_reg <= flag_invalid_next;
         en_invalid_reg <= en_invalid_next;
         nan_dflt_reg <= nan_dflt_next;
         cause_reg <= cause_next;
         rdata_reg <= rdata_next;
         res_valid_reg <= res_valid_next;
         res_reg <= res_next;
         exc_reg <= exc_next;
      end
   end

   // outputs come straight from the flops, no logic behind them
   assign res_valid = res_valid_reg;
   assign res = res_reg;
   assign exc = exc_reg;
   assign reg_rdata = rdata_reg;
endmodule : frt_unit
`default_nettype wire

// *** tb/frt_unit_assertions.sv ***
// concurrent checks on the ports of the round-to-integer unit
`timescale 1ns/1ps
`default_nettype none
module frt_unit_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // issue and result
   input wire logic req_valid,
   input wire frt_pkg::frt_req_t req,
   input wire logic cop1_enable,
   input wire logic res_valid,
   input wire frt_pkg::frt_res_t res,
   input wire frt_pkg::frt_exc_t exc,
   // register port
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // answer timing, and the fields that follow the request
   a_res_one_cycle: assert property (req_valid |=> res_valid) else $error("result late");
   a_res_no_spurious: assert property (!req_valid |=> !res_valid) else $error("stray result");
   a_dst_follows: assert property (req_valid |=> !res.we || res.dst == $past(req.dst))
      else $error("wrong destination");
   a_fmt_kept: assert property (req_valid && req.op == frt_pkg::FRT_OP_INTG |=>
      !res.we || res.fmt == $past(req.fmt)) else $error("format changed");
   a_long_tag: assert property (req_valid && req.op == frt_pkg::FRT_OP_RND_L |=>
      !res.we || res.fmt == frt_pkg::FRT_TAG_L) else $error("long tag wrong");
   // exceptions block the write and have a fixed priority
   a_cop_first: assert property (req_valid && !cop1_enable |=> exc == 3'b100 && !res.we)
      else $error("unusable missed");
   a_rsvd_op: assert property (req_valid && cop1_enable
      && req.op == frt_pkg::FRT_OP_RSVD |=> exc == 3'b010 && !res.we)
      else $error("reserved missed");
   a_trap_nowrite: assert property (res_valid && exc.invalid_trap |-> !res.we)
      else $error("trap wrote");
   a_exc_with_res: assert property (!res_valid |-> exc == 3'b000) else $error("stray exc");
   // narrow results leave the upper word clear
   a_upper_zero: assert property (res_valid && res.we
      && res.fmt inside {frt_pkg::FRT_TAG_W, frt_pkg::FRT_TAG_S} |-> res.data[63:32] == 32'h0)
      else $error("upper word");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data idle");
endmodule : frt_unit_chk
bind frt_unit frt_unit_chk u_chk (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
   .cop1_enable(cop1_enable), .res_valid(res_valid), .res(res), .exc(exc), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata));
`default_nettype wire

// *** tb/frt_pipe_model.sv ***
// pipeline issue stage model that feeds instructions to the unit
`timescale 1ns/1ps
`default_nettype none
module frt_pipe_model (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // bench side
   input wire logic go,
   input wire frt_pkg::frt_req_t go_req,
   input wire logic go_cop,
   // toward the unit
   output logic req_valid,
   output frt_pkg::frt_req_t req,
   output logic cop1_enable
);
   // known levels before the first edge
   initial begin
      req_valid = 1'b0;
      req = '0;
      cop1_enable = 1'b0;
   end
   // one issue slot; idle slots drop req_valid and show inverted stale operands
   always @(posedge mclk) begin
      req_valid <= nrst && go;
      cop1_enable <= go_cop;
      req <= !nrst ? '0 : go ? go_req : ~req;
   end
endmodule : frt_pipe_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the round-to-integer unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      frt_pkg::frt_res_t r;
      frt_pkg::frt_exc_t e;
   } frt_tb_exp_t;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic go = 1'b0;
   logic go_cop = 1'b0;
   frt_pkg::frt_req_t go_req = '0;
   logic req_valid;
   frt_pkg::frt_req_t req;
   logic cop1_enable;
   logic res_valid;
   frt_pkg::frt_res_t res;
   frt_pkg::frt_exc_t exc;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic rd_seen = 1'b0;
   logic [31:0] rnd = 32'h0001_2461;
   int bad_count = 0;
   int samples_checked = 0;
   frt_tb_exp_t res_q[$];
   logic [31:0] rd_q[$];
   // round-to-integral of +2.5, -2.5 (double) and +2.5 (single) per direction
   logic [63:0] rp[4] = '{64'h4000000000000000, 64'h4000000000000000, 64'h4008000000000000,
      64'h4000000000000000};
   logic [63:0] rn[4] = '{64'hc000000000000000, 64'hc000000000000000, 64'hc000000000000000,
      64'hc008000000000000};
   logic [63:0] rs[4] = '{64'h40000000, 64'h40000000, 64'h40400000, 64'h40000000};

   always #5 mclk = ~mclk;

   frt_pipe_model pipe (.mclk(mclk), .nrst(nrst), .go(go), .go_req(go_req), .go_cop(go_cop),
      .req_valid(req_valid), .req(req), .cop1_enable(cop1_enable));
   frt_unit dut (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
      .cop1_enable(cop1_enable), .res_valid(res_valid), .res(res), .exc(exc),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // each strobe is written once per edge, so back-to-back steps never race
   task automatic step(input logic g, input logic w, input logic r);
      @(posedge mclk);
      go <= g;
      reg_wr <= w;
      reg_rd <= r;
   endtask : step
   task automatic idle(input int n);
      repeat (n) step(1'b0, 1'b0, 1'b0);
   endtask : idle
   // gaps keep register accesses clear of results still in flight
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      idle(3);
      step(1'b0, 1'b1, 1'b0);
      reg_addr <= a;
      reg_wdata <= d;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] d);
      idle(3);
      step(1'b0, 1'b0, 1'b1);
      reg_addr <= a;
      rd_q.push_back(d);
   endtask : rd
   // c holds {op, fmt}; e is the expected exception, zero means a write
   task automatic issue(input logic [3:0] c, input logic [63:0] s, input logic [63:0] d,
         input logic [2:0] e);
      frt_tb_exp_t x;
      rnd = xs(rnd);
      step(1'b1, 1'b0, 1'b0);
      go_req <= '{op: frt_pkg::frt_op_t'(c[3:2]), fmt: frt_pkg::frt_tag_t'(c[1:0]),
         dst: rnd[4:0], src: s};
      go_cop <= (e != 3'b100);
      x.r.we = (e == 3'b000);
      x.r.fmt = c[3:2] == 2'h0 ? frt_pkg::frt_tag_t'(c[1:0]) :
         c[3:2] == 2'h1 ? frt_pkg::FRT_TAG_L : frt_pkg::FRT_TAG_W;
      x.r.dst = rnd[4:0];
      x.r.data = d;
      x.e = e;
      res_q.push_back(x);
   endtask : issue
   task automatic complete_run;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // results return in issue order; data is only meaningful when written
   always @(posedge mclk) begin
      frt_tb_exp_t x;
      logic [31:0] y;
      if (res_valid === 1'b1) begin
         x = res_q.pop_front();
         samples_checked++;
         if (res.we !== x.r.we || exc !== x.e || (x.r.we && res !== x.r)) begin
            bad_count++;
            $display("[FAIL] %0t got %h %h exp %h %h", $time, res, exc, x.r, x.e);
         end
      end
      if (rd_seen) begin
         y = rd_q.pop_front();
         samples_checked++;
         if (reg_rdata !== y) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, reg_rdata, y);
         end
      end
      rd_seen <= reg_rd;
   end

   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rd(frt_pkg::FRT_ADDR_CSR, 32'h20);
      rd(frt_pkg::FRT_ADDR_CAUSE, 32'h0);
      wr(4'h8, 32'hffffffff);
      rd(4'h8, 32'h0);
      rd(frt_pkg::FRT_ADDR_CSR, 32'h20);
      for (int m = 0; m < 4; m++) begin
         wr(frt_pkg::FRT_ADDR_CSR, 32'h20 | 32'(m));
         issue(4'h1, 64'h4004000000000000, rp[m], 3'h0);
         issue(4'h1, 64'hc004000000000000, rn[m], 3'h0);
         issue(4'h0, 64'h40200000, rs[m], 3'h0);
      end
      rd(frt_pkg::FRT_ADDR_CSR, 32'h27);
      wr(frt_pkg::FRT_ADDR_CSR, 32'h20);
      issue(4'h1, 64'h3ff0000000000000, 64'h3ff0000000000000, 3'h0);
      rd(frt_pkg::FRT_ADDR_CSR, 32'h20);
      rd(frt_pkg::FRT_ADDR_CAUSE, 32'h0);
      wr(frt_pkg::FRT_ADDR_CSR, 32'h21);
      issue(4'h5, 64'h4004000000000000, 64'h2, 3'h0);
      issue(4'h5, 64'h400c000000000000, 64'h4, 3'h0);
      issue(4'h5, 64'hc004000000000000, 64'hfffffffffffffffe, 3'h0);
      issue(4'h1, 64'hbfe8000000000000, 64'h8000000000000000, 3'h0);
      issue(4'h8, 64'h40200000, 64'h2, 3'h0);
      issue(4'h8, 64'h3fc00000, 64'h2, 3'h0);
      issue(4'h9, 64'hc00c000000000000, 64'hfffffffc, 3'h0);
      rd(frt_pkg::FRT_ADDR_CSR, 32'h25);
      rd(frt_pkg::FRT_ADDR_CAUSE, 32'h1);
      wr(frt_pkg::FRT_ADDR_CSR, 32'h20);
      issue(4'h9, 64'hc1e0000000000000, frt_pkg::FRT_W_NEG_MIN, 3'h0);
      issue(4'h9, 64'h7ff0000000000000, frt_pkg::FRT_W_POS_MAX, 3'h0);
      issue(4'h8, 64'h7f800000, frt_pkg::FRT_W_POS_MAX, 3'h0);
      issue(4'h9, 64'hfff0000000000000, frt_pkg::FRT_W_NEG_MIN, 3'h0);
      issue(4'h9, 64'h7ff8000000000000, 64'h0, 3'h0);
      issue(4'h9, 64'h41e0000000000000, frt_pkg::FRT_W_POS_MAX, 3'h0);
      issue(4'h1, 64'h7ff0000000000001, 64'h7ff8000000000001, 3'h0);
      issue(4'h5, 64'h43e0000000000000, frt_pkg::FRT_L_POS_MAX, 3'h0);
      issue(4'h5, 64'hc3f0000000000000, frt_pkg::FRT_L_NEG_MIN, 3'h0);
      rd(frt_pkg::FRT_ADDR_CSR, 32'h28);
      rd(frt_pkg::FRT_ADDR_CAUSE, 32'h2);
      wr(frt_pkg::FRT_ADDR_CSR, 32'h0);
      issue(4'h9, 64'hfff0000000000000, frt_pkg::FRT_W_POS_MAX, 3'h0);
      issue(4'h5, 64'h7ff8000000000000, frt_pkg::FRT_L_POS_MAX, 3'h0);
      wr(frt_pkg::FRT_ADDR_CSR, 32'h30);
      issue(4'h5, 64'h7ff0000000000000, 64'h0, 3'h1);
      issue(4'h5, 64'h3ff0000000000000, 64'h1, 3'h0);
      rd(frt_pkg::FRT_ADDR_CSR, 32'h38);
      // mid-run reset must bring the control word back to its reset value
      idle(3);
      nrst <= 1'b0;
      idle(2);
      nrst <= 1'b1;
      rd(frt_pkg::FRT_ADDR_CSR, 32'h20);
      rd(frt_pkg::FRT_ADDR_CAUSE, 32'h0);
      issue(4'h9, 64'h3ff0000000000000, 64'h0, 3'h4);
      issue(4'hd, 64'h3ff0000000000000, 64'h0, 3'h2);
      issue(4'h6, 64'h1, 64'h0, 3'h2);
      issue(4'h3, 64'h1, 64'h0, 3'h2);
      idle(4);
      // a result or read that never came back is a mismatch too
      if (res_q.size() != 0 || rd_q.size() != 0) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, res_q.size() + rd_q.size(), 0);
      end
      complete_run();
   end

   // cuts a hang short well past the roughly 150 cycles the run needs
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
